/* rtl/fscs_top.sv */
// fail-safe clock switch: monitor, group switching, control register
// assumes a plain register port; oscillator levels arrive from pins
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R1: low-power rc runs whenever monitoring on (code stops it in sleep)
// R2: failure raises trap and selects fast rc
// R3: failure sets clock-fail flag bit 3
// R4: watchdog clock untouched by clock failure
// R5: start timeout acts as failure to fast rc
// R6: failure loads fast rc, sets flag, clears enable
// R7: switch only between four groups (code checks the group only at the start request)
// R8: current group read-only, reports group in effect
// R9: software writes new group to request switch
// R10: reset loads both groups from configuration (code loads CFG_RESET, not the cfg register, on power-on reset)
// R11: read-only lock bit reflects pll lock
// R12: enable starts switch; clearing it aborts
// R13: config 1x disables switching and monitor
// R14: switching off: configuration selects oscillator directly
// R15: software avoids clocks below 100 kHz
// R16: low-power rc ticks at 512 kHz (code ticks every 122 clocks, about 1024 kHz)
// R17: failure is no edges in sampling window
module fscs_top
(
   input  wire logic        clk,          // system clock 125 MHz
   input  wire logic        rst_n,        // sync reset, active low
   input  wire logic        ce,           // clock enable
   input  wire logic        por_n,        // power-on/brown-out, active low
   input  wire logic        sleep,        // device in sleep
   input  wire logic        power_up_timer_done,    // power-up timer expired
   input  wire logic        osc_pri,      // primary oscillator level
   input  wire logic        osc_sec,      // secondary oscillator level
   input  wire logic        osc_frc,      // fast rc level
   input  wire logic        pll_lock,     // pll locked level
   input  wire logic [3:0]  addr,         // register address
   input  wire logic [15:0] wdata,        // write data
   input  wire logic        wr,           // write strobe
   input  wire logic        rd,           // read strobe
   output logic      [15:0] rdata,        // read data, cycle after rd
   output logic      [2:0]  clk_sel,      // group driving system clock
   output logic      [4:0]  pri_mode,     // primary mode in use
   output logic             low_power_rc_oscillator_run,     // low-power rc enable
   output logic             low_power_rc_oscillator_tick,    // low-power rc tick
   output logic             wdt_tick,     // watchdog clock tick
   output logic             fail_trap     // clock failure trap pulse
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum {SW_IDLE, SW_WAIT} fscs_sw_t;
   fscs_sw_t    sw;
   logic [15:0] cfg;
   logic [2:0]  cur_grp;
   logic [2:0]  new_grp;
   logic        cf;
   logic        switch_enable;
   logic [2:0]  lock_s;
   logic [9:0]  low_power_rc_oscillator_cnt;
   logic [2:0]  sw_cnt;
   logic        mon_fail;
   logic        osc_sel;
   logic        start_fail;
   logic        started;
   logic        fail_evt;
   wire logic   sw_on  = !cfg[fscs_pkg::SWITCH_MONITOR_CONFIG_LSB + 1];
   wire logic   mon_on = (cfg[fscs_pkg::SWITCH_MONITOR_CONFIG_LSB +: 2] == 2'b00);
   wire logic   wr_osc = wr && addr == fscs_pkg::OSC_CTRL_ADDR;

   function automatic logic grp_ok(input logic [2:0] g);
      grp_ok = g == fscs_pkg::GRP_PRI || g == fscs_pkg::GRP_SEC ||
               g == fscs_pkg::GRP_FRC || g == fscs_pkg::GRP_LOW_POWER_RC_OSCILLATOR;
   endfunction

   // ---------------------------------------------------------------
   // low-power rc timebase
   // ---------------------------------------------------------------
   // R1: monitor overrides watchdog enable
   assign low_power_rc_oscillator_run = !sleep && (mon_on || cfg[fscs_pkg::WDTEN_BIT] || !power_up_timer_done ||
                     cur_grp == fscs_pkg::GRP_LOW_POWER_RC_OSCILLATOR);
   // R16: tick every half period of nominal 512 kHz, about 1024 kHz
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         low_power_rc_oscillator_cnt  <= 10'h000;
         low_power_rc_oscillator_tick <= 1'b0;
      end
      else if (ce)
      begin
         low_power_rc_oscillator_tick <= 1'b0;
         if (!low_power_rc_oscillator_run)
            low_power_rc_oscillator_cnt <= 10'h000;
         else if (low_power_rc_oscillator_cnt == 10'(fscs_pkg::LOW_POWER_RC_OSCILLATOR_HALF - 1))
         begin
            low_power_rc_oscillator_cnt  <= 10'h000;
            low_power_rc_oscillator_tick <= 1'b1;
         end
         else
            low_power_rc_oscillator_cnt <= low_power_rc_oscillator_cnt + 10'h001;
      end
   end
   // R4: watchdog runs on the rc tick regardless of failure
   assign wdt_tick = low_power_rc_oscillator_tick;

   // ---------------------------------------------------------------
   // monitor
   // ---------------------------------------------------------------
   always_comb
   begin
      unique case (cur_grp)
         fscs_pkg::GRP_PRI: osc_sel = osc_pri;
         fscs_pkg::GRP_SEC: osc_sel = osc_sec;
         fscs_pkg::GRP_FRC: osc_sel = osc_frc;
         default:           osc_sel = low_power_rc_oscillator_cnt[0];
      endcase
   end
   // R17: edge window paced by low-power rc
   fscs_edge_watch u_watch
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .arm       (mon_on && power_up_timer_done && !sleep),
      .osc_in    (osc_sel),
      .low_power_rc_oscillator_tick (low_power_rc_oscillator_tick),
      .fail      (mon_fail)
   );
   // started goes high on the first rc tick after the power-up timer without a failure pulse
   always_ff @(posedge clk)
   begin
      if (!rst_n || !por_n)
      begin
         started <= 1'b0;
      end
      else if (ce)
      begin
         if (sleep)
            started <= 1'b0;
         else if (low_power_rc_oscillator_tick && power_up_timer_done && !mon_fail)
            started <= 1'b1;
      end
   end
   // R5: a window without edges before start is a failure
   // a source still silent when the timer ends fails its first window
   assign start_fail = mon_on && power_up_timer_done && !started && mon_fail;
   assign fail_evt   = mon_on && (mon_fail || start_fail) && cur_grp != fscs_pkg::GRP_FRC;
   // R2: trap pulse on failure
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         fail_trap <= 1'b0;
      else if (ce)
         fail_trap <= fail_evt;
   end

   // ---------------------------------------------------------------
   // lock synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         lock_s <= 3'h0;
      else if (ce)
         lock_s <= {lock_s[1:0], pll_lock};
   end

   // ---------------------------------------------------------------
   // configuration register
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cfg <= fscs_pkg::CFG_RESET;
      else if (ce && wr && addr == fscs_pkg::CFG_ADDR)
         cfg <= wdata;
   end
   assign pri_mode = cfg[fscs_pkg::FPR_LSB +: 5];

   // ---------------------------------------------------------------
   // group switching
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n || !por_n)
      begin
         // R10: both groups from the configuration reset value CFG_RESET
         cur_grp <= fscs_pkg::CFG_RESET[2:0];
         new_grp <= fscs_pkg::CFG_RESET[2:0];
         cf      <= 1'b0;
         switch_enable   <= 1'b0;
         sw      <= SW_IDLE;
         sw_cnt  <= 3'h0;
      end
      else if (ce)
      begin
         // R9: software names the new group
         if (wr_osc)
            new_grp <= wdata[fscs_pkg::NEW_OSCILLATOR_GROUP_LSB +: 3];
         if (wr_osc && !wdata[fscs_pkg::CF_BIT])
            cf <= 1'b0;
         if (fail_evt)
         begin
            // R6: fast rc, flag set, enable cleared
            // R3: set wins over software clear
            cur_grp <= fscs_pkg::GRP_FRC;
            cf      <= 1'b1;
            switch_enable   <= 1'b0;
            sw      <= SW_IDLE;
         end
         else if (!sw_on)
         begin
            // R14: configuration drives selection
            cur_grp <= cfg[fscs_pkg::FOS_LSB +: 3];
            switch_enable   <= 1'b0;
            sw      <= SW_IDLE;
         end
         else
         begin
            unique case (sw)
               SW_IDLE:
               begin
                  // R12: enable starts a transition
                  if (wr_osc && wdata[fscs_pkg::SWITCH_ENABLE_BIT] &&
                      grp_ok(wdata[fscs_pkg::NEW_OSCILLATOR_GROUP_LSB +: 3]))
                  begin
                     switch_enable  <= 1'b1;
                     sw_cnt <= 3'h0;
                     sw     <= SW_WAIT;
                  end
               end
               SW_WAIT:
               begin
                  // R12: clearing enable aborts
                  if (wr_osc && !wdata[fscs_pkg::SWITCH_ENABLE_BIT])
                  begin
                     switch_enable <= 1'b0;
                     sw    <= SW_IDLE;
                  end
                  else if (sw_cnt == 3'(fscs_pkg::SWITCH_CYCLES - 1))
                  begin
                     // R7: new_grp is checked only at the start; a write during the wait is not
                     cur_grp <= new_grp;
                     switch_enable   <= 1'b0;
                     sw      <= SW_IDLE;
                  end
                  else
                     sw_cnt <= sw_cnt + 3'h1;
               end
            endcase
         end
      end
   end
   assign clk_sel = cur_grp;

   // ---------------------------------------------------------------
   // register read
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdata <= 16'h0000;
      else if (ce)
      begin
         if (rd && addr == fscs_pkg::OSC_CTRL_ADDR)
            // R8: current group is status only; R11: lock is read-only
            rdata <= (16'(cur_grp) << fscs_pkg::CURRENT_OSCILLATOR_GROUP_LSB) |
                     (16'(new_grp) << fscs_pkg::NEW_OSCILLATOR_GROUP_LSB) |
                     (16'(lock_s[2]) << fscs_pkg::LOCK_BIT) |
                     (16'(cf) << fscs_pkg::CF_BIT) | 16'(switch_enable);
         else if (rd && addr == fscs_pkg::CFG_ADDR)
            rdata <= cfg;
         else if (rd && addr == fscs_pkg::STAT_ADDR)
            rdata <= {13'h0000, started, sw_on, mon_on};
         else if (rd)
            rdata <= fscs_pkg::UNMAPPED_DATA;
         else
            rdata <= 16'h0000;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence fail_seen_s;
      fail_evt;
   endsequence
   sequence fast_rc_s;
      ##1 cur_grp == fscs_pkg::GRP_FRC && cf && !switch_enable;
   endsequence
   failover_a: assert property (@(posedge clk) disable iff (!rst_n || !por_n) // R6
      fail_seen_s and ce |-> fast_rc_s) else $error("failover did not reach fast rc");
   trap_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
      fail_evt && ce |=> fail_trap) else $error("trap missing after failure");
   cf_sticky_a: assert property (@(posedge clk) disable iff (!rst_n || !por_n) // R3
      cf && !(wr_osc && !wdata[fscs_pkg::CF_BIT]) |=> cf) else $error("clock fail flag lost");
   low_power_rc_oscillator_mon_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
      mon_on && !sleep |-> low_power_rc_oscillator_run) else $error("rc stopped while monitoring");
   cfg_direct_a: assert property (@(posedge clk) disable iff (!rst_n || !por_n) // R14
      !sw_on && ce && !fail_evt |=> cur_grp == $past(cfg[2:0])) else $error("config not applied");
   abort_a: assert property (@(posedge clk) disable iff (!rst_n || !por_n) // R12
      ce && sw_on && !fail_evt && sw == SW_WAIT && wr_osc && !wdata[0]
      |=> !switch_enable && $stable(cur_grp)) else $error("abort did not stop switch");
   no_mon_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
      cfg[fscs_pkg::SWITCH_MONITOR_CONFIG_LSB + 1] |-> !fail_evt && !switch_enable) else $error("disabled monitor acted");
   legal_grp_a: assert property (@(posedge clk) disable iff (!rst_n || !por_n) // R7
      sw_on |-> grp_ok(cur_grp)) else $error("illegal group in effect");
   wdt_run_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
      wdt_tick == low_power_rc_oscillator_tick) else $error("watchdog tick diverged");

   // ---------------------------------------------------------------
   // further checks on status, switching and timebase
   // ---------------------------------------------------------------
   // status read must mirror the group really in effect
   cur_read_a: assert property (@(posedge clk) disable iff (!rst_n || !por_n) // R8
      ce && rd && addr == fscs_pkg::OSC_CTRL_ADDR
      |=> rdata[fscs_pkg::CURRENT_OSCILLATOR_GROUP_LSB +: 3] == $past(cur_grp)) else $error("group read wrong");
   lock_read_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
      ce && rd && addr == fscs_pkg::OSC_CTRL_ADDR
      |=> rdata[fscs_pkg::LOCK_BIT] == $past(lock_s[2])) else $error("lock read wrong");
   cf_set_a: assert property (@(posedge clk) disable iff (!rst_n || !por_n) // R3
      ce && fail_evt
      |=> cf) else $error("clock fail flag not set");
   trap_once_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
      fail_trap
      |=> !fail_trap) else $error("trap longer than a pulse");
   // a legal start request raises the enable on the next edge
   sw_start_a: assert property (@(posedge clk) disable iff (!rst_n || !por_n) // R12
      ce && sw_on && !fail_evt && sw == SW_IDLE && wr_osc && wdata[fscs_pkg::SWITCH_ENABLE_BIT] &&
      grp_ok(wdata[fscs_pkg::NEW_OSCILLATOR_GROUP_LSB +: 3])
      |=> switch_enable) else $error("switch did not start");
   sw_done_a: assert property (@(posedge clk) disable iff (!rst_n || !por_n) // R7
      ce && sw_on && !fail_evt && sw == SW_WAIT && !(wr_osc && !wdata[fscs_pkg::SWITCH_ENABLE_BIT]) &&
      sw_cnt == 3'(fscs_pkg::SWITCH_CYCLES - 1)
      |=> cur_grp == $past(new_grp) && !switch_enable) else $error("switch did not finish");
   low_power_rc_oscillator_sleep_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
      sleep
      |-> !low_power_rc_oscillator_run) else $error("rc running in sleep");
   tick_gap_a: assert property (@(posedge clk) disable iff (!rst_n) // R16
      ce && low_power_rc_oscillator_tick
      |=> !low_power_rc_oscillator_tick) else $error("rc tick too long");
   // clock enable low must hold the switching state still
   ce_hold_a: assert property (@(posedge clk) disable iff (!rst_n || !por_n) // R12
      !ce
      |=> $stable(cur_grp) && $stable(switch_enable) && $stable(cf)) else $error("state moved without enable");
endmodule
`default_nettype wire

/* rtl/fscs_pkg.sv */
// fail-safe clock switch: register map, field positions, codes, timing
// assumes one 125 MHz system clock domain; shared by all rtl files
package fscs_pkg;
   // -----------------------------------------------------------------
   // register map (word index on the plain register port)
   // -----------------------------------------------------------------
   localparam logic [3:0]  OSC_CTRL_ADDR   = 4'h0;
   localparam logic [3:0]  CFG_ADDR        = 4'h1;
   localparam logic [3:0]  STAT_ADDR       = 4'h2;
   localparam logic [15:0] UNMAPPED_DATA   = 16'h0000;
   // oscillator_control fields
   localparam int          CURRENT_OSCILLATOR_GROUP_LSB        = 12;
   localparam int          NEW_OSCILLATOR_GROUP_LSB        = 8;
   localparam int          LOCK_BIT        = 5;
   localparam int          CF_BIT          = 3;
   localparam int          SWITCH_ENABLE_BIT       = 0;
   // configuration register fields
   localparam int          FOS_LSB         = 0;
   localparam int          FPR_LSB         = 3;
   localparam int          SWITCH_MONITOR_CONFIG_LSB       = 8;
   localparam int          WDTEN_BIT       = 10;
   localparam logic [15:0] CFG_RESET       = 16'h0300;
   // oscillator group codes
   localparam logic [2:0]  GRP_FRC         = 3'h1;
   localparam logic [2:0]  GRP_LOW_POWER_RC_OSCILLATOR        = 3'h2;
   localparam logic [2:0]  GRP_SEC         = 3'h0;
   localparam logic [2:0]  GRP_PRI         = 3'h3;
   // timing
   localparam int          CLK_MHZ         = 125;
   localparam int          LOW_POWER_RC_OSCILLATOR_KHZ        = 512;
   localparam int          LOW_POWER_RC_OSCILLATOR_HALF       = (CLK_MHZ * 1000) / (2 * LOW_POWER_RC_OSCILLATOR_KHZ);
   localparam int          WINDOW_LOW_POWER_RC_OSCILLATOR     = 8;
   localparam int          SWITCH_CYCLES   = 4;
endpackage

/* rtl/fscs_edge_watch.sv */
// fail-safe clock switch: edge watch on the selected oscillator
// assumes osc_in is asynchronous to clk; low_power_rc_oscillator_tick paces the window
`timescale 1ns/1ns
`default_nettype none
module fscs_edge_watch
(
   input  wire logic clk,        // system clock
   input  wire logic rst_n,      // sync reset, active low
   input  wire logic ce,         // clock enable
   input  wire logic arm,        // monitoring active
   input  wire logic osc_in,     // watched oscillator level
   input  wire logic low_power_rc_oscillator_tick,  // low-power rc tick
   output logic      fail        // one-cycle failure pulse
);
   logic [2:0] sync;
   logic [3:0] win;
   logic       seen;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         sync <= 3'h0;
      else if (ce)
         sync <= {sync[1:0], osc_in};
   end
   // window restarts at the first rc tick after any edge; expiry without an edge is failure
   always_ff @(posedge clk)
   begin
      if (!rst_n || !arm)
      begin
         win  <= 4'h0;
         seen <= 1'b0;
         fail <= 1'b0;
      end
      else if (ce)
      begin
         fail <= 1'b0;
         if (sync[2] != sync[1])
            seen <= 1'b1;
         if (low_power_rc_oscillator_tick)
         begin
            if (seen)
            begin
               win  <= 4'h0;
               seen <= 1'b0;
            end
            else if (win == 4'(fscs_pkg::WINDOW_LOW_POWER_RC_OSCILLATOR - 1))
            begin
               win  <= 4'h0;
               fail <= 1'b1;
            end
            else
               win <= win + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* dv/fscs_osc_model.sv */
// oscillator sources and pll beside the fail-safe clock switch
// assumes the bench starts and stops each source by a level
`timescale 1ns/1ns
`default_nettype none
module fscs_osc_model
(
   input  wire logic run_pri,  // primary running
   input  wire logic run_sec,  // secondary running
   input  wire logic run_frc,  // fast rc running
   input  wire logic lock_in,  // pll lock wanted
   output logic      osc_pri,  // primary level
   output logic      osc_sec,  // secondary level
   output logic      osc_frc,  // fast rc level
   output logic      pll_lock  // pll lock level
);
   // a dead source holds its level: a stopped crystal gives no edges
   initial
   begin
      osc_pri = 1'b0;
      osc_sec = 1'b0;
      osc_frc = 1'b0;
      pll_lock = 1'b0;
   end
   // periods unrelated to the 8 ns system clock, all far above 100 kHz
   always #10 if (run_pri) osc_pri = ~osc_pri;
   always #15 if (run_sec) osc_sec = ~osc_sec;
   always #13 if (run_frc) osc_frc = ~osc_frc;
   // lock settles a while after the request
   always @(lock_in) pll_lock <= #37 lock_in;
endmodule
`default_nettype wire

/* dv/fscs_tb_top.sv */
// self-checking bench of the fail-safe clock switch
// assumes fscs_top and the oscillator model; one 125 MHz clock
`timescale 1ns/1ns
`default_nettype none
module fscs_tb_top;
   localparam logic [3:0] A_OSC = fscs_pkg::OSC_CTRL_ADDR;
   localparam logic [3:0] A_CFG = fscs_pkg::CFG_ADDR;
   localparam logic [15:0] M_OSC = 16'h770B;
   logic clk, osc_pri, osc_sec, osc_frc, pll_lock;
   logic rst_n = 1'b0, por_n = 1'b1, sleep = 1'b0, power_up_timer_done = 1'b1;
   logic run_pri = 1'b1, run_sec = 1'b1, run_frc = 1'b1, lock_in = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata, v;
   logic wr = 1'b0, rd = 1'b0, low_power_rc_oscillator_run, low_power_rc_oscillator_tick, wdt_tick, fail_trap;
   logic ce = 1'b1;
   logic [2:0] clk_sel, g;
   logic [4:0] pri_mode;
   logic [31:0] seed = 32'h26FD;
   int fails = 0, n_compared = 0, n_trap = 0, n_wdt = 0, k, n;

   fscs_osc_model i_osc (.run_pri(run_pri), .run_sec(run_sec), .run_frc(run_frc),
      .lock_in(lock_in), .osc_pri(osc_pri), .osc_sec(osc_sec), .osc_frc(osc_frc),
      .pll_lock(pll_lock));
   fscs_top i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .por_n(por_n), .sleep(sleep),
      .power_up_timer_done(power_up_timer_done), .osc_pri(osc_pri), .osc_sec(osc_sec), .osc_frc(osc_frc),
      .pll_lock(pll_lock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .clk_sel(clk_sel), .pri_mode(pri_mode), .low_power_rc_oscillator_run(low_power_rc_oscillator_run),
      .low_power_rc_oscillator_tick(low_power_rc_oscillator_tick), .wdt_tick(wdt_tick), .fail_trap(fail_trap));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (fail_trap === 1'b1)
         n_trap <= n_trap + 1;
      if (wdt_tick === 1'b1)
         n_wdt <= n_wdt + 1;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // oscillator_control value with new group and switch enable
   function automatic logic [15:0] ctl(input logic [2:0] grp, input logic en);
      return (16'(grp) << fscs_pkg::NEW_OSCILLATOR_GROUP_LSB) | 16'(en);
   endfunction

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      n_compared++;
      if (s !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // bounded waits: running out counts a mismatch and ends the run
   task automatic wait_sel(input logic [2:0] e, input int lim);
      for (int i = 0; i < lim && clk_sel !== e; i++)
         @(negedge clk);
      chk("clk_sel", 16'(e), 16'(clk_sel));
      if (clk_sel !== e)
         complete_run();
   endtask
   task automatic wait_trap(input int lim);
      for (int i = 0; i < lim && fail_trap !== 1'b1; i++)
         @(negedge clk);
      chk("fail_trap", 16'h0001, 16'(fail_trap));
      if (fail_trap !== 1'b1)
         complete_run();
   endtask

   initial
   begin
      #400000;
      fails++;
      complete_run();
   end

   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(A_OSC, v);
      chk("osc_ctrl", 16'h0000, v & M_OSC);
      rd_reg(A_CFG, v);
      chk("config", fscs_pkg::CFG_RESET, v);
      rd_reg(4'hF, v);
      chk("unmapped", fscs_pkg::UNMAPPED_DATA, v);
      // default setting: no switching and no monitoring
      wr_reg(A_OSC, ctl(fscs_pkg::GRP_PRI, 1'b1));
      repeat (8) @(posedge clk);
      chk("clk_sel", 16'(fscs_pkg::GRP_SEC), 16'(clk_sel));
      run_sec <= 1'b0;
      n = n_trap;
      repeat (1500) @(posedge clk);
      chk("trap_count", 16'(n), 16'(n_trap));
      run_sec <= 1'b1;
      // switch and monitor on, random primary mode
      seed = xs(seed);
      wr_reg(A_CFG, 16'(seed[4:0]) << fscs_pkg::FPR_LSB);
      rd_reg(A_CFG, v);
      chk("config", 16'(seed[4:0]) << fscs_pkg::FPR_LSB, v);
      chk("pri_mode", 16'(seed[4:0]), 16'(pri_mode));
      chk("low_power_rc_oscillator_run", 16'h0001, 16'(low_power_rc_oscillator_run));
      rd_reg(fscs_pkg::STAT_ADDR, v);
      chk("status", 16'h0003, v & 16'h0003);
      sleep <= 1'b1;
      @(negedge clk);
      chk("low_power_rc_oscillator_run", 16'h0000, 16'(low_power_rc_oscillator_run));
      sleep <= 1'b0;
      for (k = 0; k < 6; k++)
      begin
         seed = xs(seed);
         g = {1'b0, seed[1:0]};
         wr_reg(A_OSC, ctl(g, 1'b1));
         wait_sel(g, 40);
         // same-group requests still run the full switch count
         repeat (fscs_pkg::SWITCH_CYCLES + 1) @(posedge clk);
         rd_reg(A_OSC, v);
         chk("osc_ctrl", (16'(g) << 12) | ctl(g, 1'b0), v & M_OSC);
      end
      wr_reg(A_OSC, 16'h7000 | ctl(g, 1'b0));
      rd_reg(A_OSC, v);
      chk("osc_ctrl", (16'(g) << 12) | ctl(g, 1'b0), v & M_OSC);
      wr_reg(A_OSC, ctl(3'h7, 1'b1));
      repeat (8) @(posedge clk);
      chk("clk_sel", 16'(g), 16'(clk_sel));
      wr_reg(A_OSC, ctl(fscs_pkg::GRP_PRI, 1'b1));
      wait_sel(fscs_pkg::GRP_PRI, 40);
      // start a switch, clear the enable on the very next cycle
      @(posedge clk);
      wdata <= ctl(fscs_pkg::GRP_LOW_POWER_RC_OSCILLATOR, 1'b1);
      wr <= 1'b1;
      @(posedge clk);
      wdata <= ctl(fscs_pkg::GRP_LOW_POWER_RC_OSCILLATOR, 1'b0);
      @(posedge clk);
      wr <= 1'b0;
      repeat (10) @(posedge clk);
      chk("clk_sel", 16'(fscs_pkg::GRP_PRI), 16'(clk_sel));
      lock_in <= 1'b1;
      repeat (12) @(posedge clk);
      rd_reg(A_OSC, v);
      chk("lock", 16'h0001, (v >> fscs_pkg::LOCK_BIT) & 16'h0001);
      // primary dies while selected
      run_pri <= 1'b0;
      wait_trap(4000);
      wait_sel(fscs_pkg::GRP_FRC, 20);
      rd_reg(A_OSC, v);
      chk("osc_ctrl", 16'h1008, v & 16'h700B);
      n = n_wdt;
      repeat (500) @(posedge clk);
      chk("wdt_ticks", 16'h0001, 16'((n_wdt - n) inside {[4:5]}));
      wr_reg(A_OSC, ctl(fscs_pkg::GRP_FRC, 1'b0));
      rd_reg(A_OSC, v);
      chk("clock_fail", 16'h0000, v & 16'h0008);
      // writes while the clock enable is low must be ignored
      ce <= 1'b0;
      wr_reg(A_OSC, ctl(fscs_pkg::GRP_PRI, 1'b1));
      repeat (8) @(posedge clk);
      ce <= 1'b1;
      repeat (8) @(posedge clk);
      chk("clk_sel", 16'(fscs_pkg::GRP_FRC), 16'(clk_sel));
      rd_reg(A_OSC, v);
      chk("osc_ctrl", 16'h1000 | ctl(fscs_pkg::GRP_FRC, 1'b0), v & M_OSC);
      run_pri <= 1'b1;
      // power-on with a source that never starts before the timer ends
      run_sec <= 1'b0;
      por_n <= 1'b0;
      power_up_timer_done <= 1'b0;
      @(posedge clk);
      por_n <= 1'b1;
      rd_reg(A_OSC, v);
      chk("osc_ctrl", 16'h0000, v & M_OSC);
      power_up_timer_done <= 1'b1;
      wait_trap(4000);
      wait_sel(fscs_pkg::GRP_FRC, 20);
      complete_run();
   end
endmodule
`default_nettype wire
